// >>> hw/mie_exec.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mie_defines.svh"
// Function
// - Invert: accumulator gets complement of memory byte, zero flag only.
// - Decimal adjust low nibble adds six when above nine or half carry.
// - High nibble always adds internal carry, then adds six when above nine or carry.
// - Decimal adjust writes memory, changes only the carry flag.
// - Decrement memory byte to memory or accumulator, zero flag only.
// - Increment memory byte to memory or accumulator, zero flag only.
// - Sleep stops execution, holds memory and accumulator values.
// - Sleep clears watchdog, sets sleep flag, clears expiry, advances counter.
// - Branch loads program counter from instruction, flags untouched.
// - Immediate move loads constant into accumulator, flags untouched.
// - Memory-to-accumulator move copies byte, flags untouched.
// - Accumulator-to-memory move writes byte, flags untouched.
// - Idle only advances the program counter.
// - OR with memory or constant, to accumulator or memory, zero flag.
// - Subroutine exit restores counter from stack in two cycles.
// - Return with value also loads accumulator with constant.
// - Interrupt exit restores counter and sets global interrupt enable.
// - Left rotate wraps bit seven to bit zero, no flags.
// - Rotate through carry: bit seven into carry, carry into bit zero.
// - Right rotate wraps bit zero to bit seven, writes memory.
module mie_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_req,
    output logic sys_clk_run,
    output logic wdog_clear
);
    logic [7:0] mem_ff [0:`MIE_MEM_WORDS-1];
    logic [7:0] acc_ff;
    mie_pkg::mie_flags_s flg_ff;
    logic [`MIE_PC_W-1:0] pc_ff;
    logic [`MIE_PC_W-1:0] stack_ff;
    mie_pkg::mie_cmd_s cmd_ff;
    mie_pkg::mie_state_e st_ff;
    logic [1:0] wake_sync_ff;
    logic wdog_clr_ff;
    logic wr;
    logic rd;
    logic mem_hit;
    logic [5:0] maddr;
    logic [7:0] mval;
    logic [7:0] res;
    logic res_to_mem;
    logic res_to_acc;
    logic zero_upd;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic adj_c;
    logic nxt_carry;
    logic busy;
    logic cmd_wr;
    logic nxt_wdog_clr;

    // Zero test shared by every op that updates the zero flag
    function automatic logic is_null(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // APB decode; slave answers in the access cycle, no wait states
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign cmd_wr = wr && paddr == `MIE_OFF_CMD;
    assign mem_hit = (paddr >= `MIE_OFF_MEM) && (paddr < `MIE_OFF_MEM + 12'h100);
    assign pready = 1'b1;
    // Sleep is not busy, so software can still inspect state with the clock off
    assign busy = st_ff != mie_pkg::MIE_ST_IDLE && st_ff != mie_pkg::MIE_ST_SLEEP;
    // Error for addresses above the status register outside the memory window, and command writes while executing
    assign pslverr = psel & penable & ((~mem_hit && paddr > `MIE_OFF_STATUS) ||
                     (pwrite && paddr == `MIE_OFF_CMD && busy));
    assign maddr = cmd_ff.addr[5:0];
    assign mval = mem_ff[maddr];
    // system clock gated off while asleep
    assign sys_clk_run = st_ff != mie_pkg::MIE_ST_SLEEP;
    assign wdog_clear = wdog_clr_ff;
    // watchdog and prescaler cleared as the sleep op executes
    assign nxt_wdog_clr = st_ff == mie_pkg::MIE_ST_EXEC && cmd_ff.op == mie_pkg::MIE_OP_SLEEP;

    // Decimal adjust nibble sums
    // Internal carry is the +6 carry out, not an inverted half carry
    always_comb begin
        adj_c = 1'b0;
        if ({1'b0, acc_ff[3:0]} > `MIE_BCD_LIMIT || flg_ff.half_carry_flag) begin
            lo_sum = {1'b0, acc_ff[3:0]} + `MIE_BCD_STEP;
            adj_c = lo_sum[4];
        end else begin
            lo_sum = {1'b0, acc_ff[3:0]};
        end
        hi_sum = {1'b0, acc_ff[7:4]} + {4'h0, adj_c};
        nxt_carry = flg_ff.high_bit_out_flag;
        if (hi_sum > `MIE_BCD_LIMIT || flg_ff.high_bit_out_flag) begin
            hi_sum = hi_sum + `MIE_BCD_STEP;
            nxt_carry = 1'b1;
        end
    end

    // Datapath result and destination select
    always_comb begin
        res = 8'h00;
        res_to_mem = 1'b0;
        res_to_acc = 1'b0;
        zero_upd = 1'b0;
        case (cmd_ff.op)
            mie_pkg::MIE_OP_INV_ACC: begin
                res = ~mval;
                res_to_acc = 1'b1;
                zero_upd = 1'b1;
            end
            mie_pkg::MIE_OP_DADJ: begin
                res = {hi_sum[3:0], lo_sum[3:0]};
                res_to_mem = 1'b1;
            end
            mie_pkg::MIE_OP_DEC_MEM, mie_pkg::MIE_OP_DEC_ACC: begin
                res = mval - 8'h01;
                res_to_mem = cmd_ff.op == mie_pkg::MIE_OP_DEC_MEM;
                res_to_acc = ~res_to_mem;
                zero_upd = 1'b1;
            end
            mie_pkg::MIE_OP_INC_MEM, mie_pkg::MIE_OP_INC_ACC: begin
                res = mval + 8'h01;
                res_to_mem = cmd_ff.op == mie_pkg::MIE_OP_INC_MEM;
                res_to_acc = ~res_to_mem;
                zero_upd = 1'b1;
            end
            mie_pkg::MIE_OP_MOV_IMM: begin
                res = cmd_ff.imm;
                res_to_acc = 1'b1;
            end
            mie_pkg::MIE_OP_RET_VAL: begin
                res = cmd_ff.imm;
                res_to_acc = 1'b1;
            end
            mie_pkg::MIE_OP_MOV_M2A: begin
                res = mval;
                res_to_acc = 1'b1;
            end
            mie_pkg::MIE_OP_MOV_A2M: begin
                res = acc_ff;
                res_to_mem = 1'b1;
            end
            mie_pkg::MIE_OP_OR_MEM, mie_pkg::MIE_OP_OR_TOMEM: begin
                res = acc_ff | mval;
                res_to_mem = cmd_ff.op == mie_pkg::MIE_OP_OR_TOMEM;
                res_to_acc = ~res_to_mem;
                zero_upd = 1'b1;
            end
            mie_pkg::MIE_OP_OR_IMM: begin
                res = acc_ff | cmd_ff.imm;
                res_to_acc = 1'b1;
                zero_upd = 1'b1;
            end
            mie_pkg::MIE_OP_ROL_MEM, mie_pkg::MIE_OP_ROL_ACC: begin
                res = {mval[6:0], mval[7]};
                res_to_mem = cmd_ff.op == mie_pkg::MIE_OP_ROL_MEM;
                res_to_acc = ~res_to_mem;
            end
            mie_pkg::MIE_OP_RLC_MEM, mie_pkg::MIE_OP_RLC_ACC: begin
                res = {mval[6:0], flg_ff.high_bit_out_flag};
                res_to_mem = cmd_ff.op == mie_pkg::MIE_OP_RLC_MEM;
                res_to_acc = ~res_to_mem;
            end
            mie_pkg::MIE_OP_ROR_MEM: begin
                res = {mval[0], mval[7:1]};
                res_to_mem = 1'b1;
            end
            // Unknown codes act as idle and write nothing
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // Wake request is a pin, so synchronise it
    // Only the second flop is read; the first may still be settling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_sync_ff <= 2'b00;
        end else begin
            wake_sync_ff <= {wake_sync_ff[0], wake_req};
        end
    end

    // Sequencer; return takes a second cycle in WAIT
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= mie_pkg::MIE_ST_IDLE;
        end else begin
            case (st_ff)
                mie_pkg::MIE_ST_IDLE: begin
                    if (cmd_wr) begin
                        st_ff <= mie_pkg::MIE_ST_EXEC;
                    end
                end
                mie_pkg::MIE_ST_EXEC: begin
                    if (cmd_ff.op == mie_pkg::MIE_OP_RET || cmd_ff.op == mie_pkg::MIE_OP_RET_VAL
                        || cmd_ff.op == mie_pkg::MIE_OP_RET_IRQ) begin
                        st_ff <= mie_pkg::MIE_ST_WAIT;
                    end else if (cmd_ff.op == mie_pkg::MIE_OP_SLEEP) begin
                        st_ff <= mie_pkg::MIE_ST_SLEEP;
                    end else begin
                        st_ff <= mie_pkg::MIE_ST_IDLE;
                    end
                end
                mie_pkg::MIE_ST_WAIT: begin
                    st_ff <= mie_pkg::MIE_ST_IDLE;
                end
                mie_pkg::MIE_ST_SLEEP: begin
                    // clock stays off until the synchronised wake level
                    if (wake_sync_ff[1]) begin
                        st_ff <= mie_pkg::MIE_ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= mie_pkg::MIE_ST_IDLE;
                end
            endcase
        end
    end

    // Command capture; ignored unless idle
    // Software polls status first; a command sent in any other state is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= '0;
        end else if (cmd_wr && st_ff == mie_pkg::MIE_ST_IDLE) begin
            cmd_ff <= {mie_pkg::mie_op_e'(pwdata[`MIE_CMD_OP_LSB +: 5]),
                       pwdata[`MIE_CMD_AD_LSB +: 8], pwdata[7:0]};
        end
    end

    // Data memory; software port and execution write back
    // No reset: plain storage, undefined until written
    always_ff @(posedge pclk) begin
        if (st_ff == mie_pkg::MIE_ST_EXEC && res_to_mem) begin
            mem_ff[maddr] <= res;
        end else if (wr && mem_hit && !busy) begin
            mem_ff[paddr[7:2]] <= pwdata[7:0];
        end
    end

    // Accumulator
    // Execution write back beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= `MIE_ACC_RST;
        end else if (st_ff == mie_pkg::MIE_ST_EXEC && res_to_acc) begin
            acc_ff <= res;
        end else if (wr && paddr == `MIE_OFF_ACC && !busy) begin
            acc_ff <= pwdata[7:0];
        end
    end

    // Status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flg_ff <= `MIE_FLG_RST;
        end else if (st_ff == mie_pkg::MIE_ST_EXEC) begin
            if (zero_upd) begin
                flg_ff.result_null_flag <= is_null(res);
            end
            // carry set when the high nibble needed a fixup
            if (cmd_ff.op == mie_pkg::MIE_OP_DADJ) begin
                flg_ff.high_bit_out_flag <= nxt_carry;
            end
            if (cmd_ff.op == mie_pkg::MIE_OP_RLC_MEM || cmd_ff.op == mie_pkg::MIE_OP_RLC_ACC) begin
                flg_ff.high_bit_out_flag <= mval[7];
            end
            if (cmd_ff.op == mie_pkg::MIE_OP_SLEEP) begin
                flg_ff.sleep_entered_flag <= 1'b1;
                flg_ff.watchdog_expired_flag <= 1'b0;
            end
            if (cmd_ff.op == mie_pkg::MIE_OP_RET_IRQ) begin
                flg_ff.global_irq_enable <= 1'b1;
            end
        end else if (wr && paddr == `MIE_OFF_FLAGS && !busy) begin
            // Software write replaces all seven flags at once
            flg_ff <= pwdata[6:0];
        end
    end

    // Program counter and return stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_ff <= `MIE_PC_RST;
            stack_ff <= `MIE_PC_RST;
        end else if (st_ff == mie_pkg::MIE_ST_EXEC) begin
            case (cmd_ff.op)
                mie_pkg::MIE_OP_BRANCH: begin
                    pc_ff <= {cmd_ff.addr[1:0], cmd_ff.imm};
                end
                mie_pkg::MIE_OP_RET, mie_pkg::MIE_OP_RET_VAL, mie_pkg::MIE_OP_RET_IRQ: begin
                    pc_ff <= stack_ff;
                end
                // advance by one
                // Sleep lands here too, so the counter steps past it
                default: begin
                    pc_ff <= pc_ff + 10'h001;
                end
            endcase
        end else if (wr && !busy && paddr == `MIE_OFF_PC) begin
            pc_ff <= pwdata[9:0];
        end else if (wr && !busy && paddr == `MIE_OFF_STACK) begin
            // One-level stack, loaded by software in place of a call
            stack_ff <= pwdata[9:0];
        end
    end

    // Watchdog clear pulse to the watchdog and prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_clr_ff <= 1'b0;
        end else begin
            // Registered so the watchdog sees a clean one-cycle pulse
            wdog_clr_ff <= nxt_wdog_clr;
        end
    end

    // Read mux; combinational so data is ready in the access cycle
    // Writes and unmapped reads show zero so nothing stale leaks out
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            if (mem_hit) begin
                prdata = {24'h00_0000, mem_ff[paddr[7:2]]};
            end else begin
                case (paddr)
                    `MIE_OFF_CMD: prdata = {11'h0, cmd_ff.op, cmd_ff.addr, cmd_ff.imm};
                    `MIE_OFF_ACC: prdata = {24'h00_0000, acc_ff};
                    `MIE_OFF_FLAGS: prdata = {25'h0, flg_ff};
                    `MIE_OFF_PC: prdata = {22'h0, pc_ff};
                    `MIE_OFF_STACK: prdata = {22'h0, stack_ff};
                    `MIE_OFF_STATUS: prdata = {30'h0, st_ff};
                    default: prdata = 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// >>> hw/mie_defines.svh
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH
// Register byte offsets
`define MIE_OFF_CMD    12'h000
`define MIE_OFF_ACC    12'h004
`define MIE_OFF_FLAGS  12'h008
`define MIE_OFF_PC     12'h00c
`define MIE_OFF_STACK  12'h010
`define MIE_OFF_STATUS 12'h014
`define MIE_OFF_MEM    12'h100
// Command register fields
`define MIE_CMD_OP_LSB 16
`define MIE_CMD_AD_LSB 8
// Flag register bit positions
`define MIE_FLG_ZERO  0
`define MIE_FLG_CARRY 1
`define MIE_FLG_HALF  2
`define MIE_FLG_OVF   3
`define MIE_FLG_SLEEP 4
`define MIE_FLG_WDOG  5
`define MIE_FLG_GIE   6
// Decimal adjust constants
`define MIE_BCD_LIMIT 5'h09
`define MIE_BCD_STEP  5'h06
// Sizes and reset values
`define MIE_MEM_WORDS 64
`define MIE_PC_W      10
`define MIE_ACC_RST   8'h00
`define MIE_FLG_RST   7'h00
`define MIE_PC_RST    10'h000
`endif

// >>> hw/mie_pkg.sv
package mie_pkg;
    typedef enum logic [4:0] {
        MIE_OP_IDLE = 5'h00, MIE_OP_INV_ACC = 5'h01, MIE_OP_DADJ = 5'h02,
        MIE_OP_DEC_MEM = 5'h03, MIE_OP_DEC_ACC = 5'h04, MIE_OP_INC_MEM = 5'h05,
        MIE_OP_INC_ACC = 5'h06, MIE_OP_SLEEP = 5'h07, MIE_OP_BRANCH = 5'h08,
        MIE_OP_MOV_IMM = 5'h09, MIE_OP_MOV_M2A = 5'h0a, MIE_OP_MOV_A2M = 5'h0b,
        MIE_OP_OR_MEM = 5'h0c, MIE_OP_OR_IMM = 5'h0d, MIE_OP_OR_TOMEM = 5'h0e,
        MIE_OP_RET = 5'h0f, MIE_OP_RET_VAL = 5'h10, MIE_OP_RET_IRQ = 5'h11,
        MIE_OP_ROL_MEM = 5'h12, MIE_OP_ROL_ACC = 5'h13, MIE_OP_RLC_MEM = 5'h14,
        MIE_OP_RLC_ACC = 5'h15, MIE_OP_ROR_MEM = 5'h16
    } mie_op_e;
    // Gray-coded sequencer states
    typedef enum logic [1:0] {
        MIE_ST_IDLE = 2'b00, MIE_ST_EXEC = 2'b01, MIE_ST_WAIT = 2'b11, MIE_ST_SLEEP = 2'b10
    } mie_state_e;
    typedef struct packed {
        logic global_irq_enable;
        logic watchdog_expired_flag;
        logic sleep_entered_flag;
        logic twos_complement_range_flag;
        logic half_carry_flag;
        logic high_bit_out_flag;
        logic result_null_flag;
    } mie_flags_s;
    typedef struct packed {
        mie_op_e op;
        logic [7:0] addr;
        logic [7:0] imm;
    } mie_cmd_s;
endpackage

// >>> sim/mie_exec_monitor.sv
`timescale 1ns/1ps
module mie_exec_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_req,
    input wire logic sys_clk_run,
    input wire logic wdog_clear
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus answers with no wait states
    chk_ready_in_access: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    chk_err_access_only: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    // Hole in the map is refused and reads zero
    chk_hole_refused: assert property (psel && penable && paddr == 12'h018 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_mem_accepted: assert property (psel && penable && !pwrite && paddr[11:8] == 4'h1 |-> !pslverr)
        else $error("memory read refused");
    chk_sleep_status: assert property (psel && !pwrite && paddr == 12'h014 && !sys_clk_run |-> prdata == 32'h2)
        else $error("status wrong while clock stopped");
    chk_sleep_hold: assert property ((!sys_clk_run && !wake_req) [*3] |=> !sys_clk_run)
        else $error("clock restarted without wake request");
    chk_wake_bound: assert property ($rose(wake_req) && !sys_clk_run |-> ##[1:6] sys_clk_run)
        else $error("no restart after wake request");
    chk_wdog_pulse: assert property (wdog_clear |=> !wdog_clear)
        else $error("watchdog clear wider than one cycle");
    chk_stop_clears_wdog: assert property ($fell(sys_clk_run) |-> wdog_clear)
        else $error("clock stop without watchdog clear");
    chk_wdog_in_sleep: assert property (wdog_clear |-> !sys_clk_run)
        else $error("watchdog clear while running");
endmodule
bind mie_exec mie_exec_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_req(wake_req), .sys_clk_run(sys_clk_run),
    .wdog_clear(wdog_clear));

// >>> sim/tb_mie_exec.sv
`timescale 1ns/1ps
module tb_mie_exec;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic wake_req = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, sys_clk_run, wdog_clear;
    logic wd_seen = 1'b0;
    logic [31:0] q;
    logic e;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #25 pclk = ~pclk;
    mie_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_req(wake_req), .sys_clk_run(sys_clk_run),
        .wdog_clear(wdog_clear));
    // Clear pulse lasts one cycle, so latch it; also bound the run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (wdog_clear === 1'b1) wd_seen <= 1'b1;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Select stays up at the end so a follower can go back to back
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the very edge that sees pready high
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
    endtask
    task automatic rel();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        rel();
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        rel();
    endtask
    function automatic logic [11:0] ma(input logic [7:0] a);
        return {4'h1, a[5:0], 2'b00};
    endfunction
    // Poll the state word, bounded
    task automatic poll(input logic [31:0] st);
        for (int i = 0; i < 20; i++) begin
            rd(12'h014);
            if (q === st) break;
        end
        chk("status", st, q);
    endtask
    task automatic t(input mie_pkg::mie_op_e op, input logic [7:0] a, x, m, ac,
        input logic [6:0] f, input logic [7:0] ea, em, input logic [6:0] ef);
        wr(ma(a), {24'h0, m});
        wr(12'h004, {24'h0, ac});
        wr(12'h008, {25'h0, f});
        wr(12'h000, {11'h0, op, a, x});
        poll(32'h0);
        rd(12'h004);
        chk("acc", {24'h0, ea}, q);
        rd(ma(a));
        chk("mem", {24'h0, em}, q);
        rd(12'h008);
        chk("flags", {25'h0, ef}, q);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h018);
        chk("hole data", 32'h0, q);
        chk("hole error", 32'h1, {31'h0, e});
        t(mie_pkg::MIE_OP_INV_ACC, 8'h5, 8'h0, 8'hff, 8'h12, 7'h2a, 8'h0, 8'hff, 7'h2b);
        t(mie_pkg::MIE_OP_INV_ACC, 8'h3f, 8'h0, 8'h0f, 8'h0, 7'h7f, 8'hf0, 8'h0f, 7'h7e);
        t(mie_pkg::MIE_OP_DADJ, 8'h5, 8'h0, 8'h0, 8'h9a, 7'h79, 8'h9a, 8'h0, 7'h7b);
        t(mie_pkg::MIE_OP_DADJ, 8'h5, 8'h0, 8'h0, 8'h41, 7'h04, 8'h41, 8'h47, 7'h04);
        t(mie_pkg::MIE_OP_DADJ, 8'h5, 8'h0, 8'h0, 8'h20, 7'h02, 8'h20, 8'h80, 7'h02);
        t(mie_pkg::MIE_OP_DADJ, 8'h5, 8'h0, 8'h0, 8'h99, 7'h00, 8'h99, 8'h99, 7'h00);
        t(mie_pkg::MIE_OP_DEC_MEM, 8'h5, 8'h0, 8'h01, 8'h0, 7'h2a, 8'h0, 8'h0, 7'h2b);
        t(mie_pkg::MIE_OP_DEC_ACC, 8'h5, 8'h0, 8'h0, 8'h33, 7'h01, 8'hff, 8'h0, 7'h00);
        t(mie_pkg::MIE_OP_INC_MEM, 8'h5, 8'h0, 8'hff, 8'h0, 7'h00, 8'h0, 8'h0, 7'h01);
        t(mie_pkg::MIE_OP_INC_ACC, 8'h5, 8'h0, 8'h7f, 8'h0, 7'h55, 8'h80, 8'h7f, 7'h54);
        t(mie_pkg::MIE_OP_MOV_IMM, 8'h5, 8'h0, 8'h0, 8'h77, 7'h2a, 8'h0, 8'h0, 7'h2a);
        t(mie_pkg::MIE_OP_MOV_M2A, 8'h5, 8'h0, 8'h0, 8'h11, 7'h2a, 8'h0, 8'h0, 7'h2a);
        t(mie_pkg::MIE_OP_MOV_A2M, 8'h5, 8'h0, 8'h0, 8'h5a, 7'h55, 8'h5a, 8'h5a, 7'h55);
        t(mie_pkg::MIE_OP_OR_MEM, 8'h5, 8'h0, 8'h0, 8'h0, 7'h2a, 8'h0, 8'h0, 7'h2b);
        t(mie_pkg::MIE_OP_OR_IMM, 8'h5, 8'h03, 8'h0c, 8'h30, 7'h01, 8'h33, 8'h0c, 7'h00);
        t(mie_pkg::MIE_OP_OR_TOMEM, 8'h5, 8'h0, 8'hf0, 8'h0f, 7'h2a, 8'h0f, 8'hff, 7'h2a);
        t(mie_pkg::MIE_OP_ROL_MEM, 8'h5, 8'h0, 8'h81, 8'h0, 7'h55, 8'h0, 8'h03, 7'h55);
        t(mie_pkg::MIE_OP_ROL_ACC, 8'h5, 8'h0, 8'h40, 8'h0, 7'h2a, 8'h80, 8'h40, 7'h2a);
        t(mie_pkg::MIE_OP_RLC_MEM, 8'h5, 8'h0, 8'h80, 8'h0, 7'h00, 8'h0, 8'h0, 7'h02);
        t(mie_pkg::MIE_OP_RLC_ACC, 8'h5, 8'h0, 8'h01, 8'h0, 7'h2a, 8'h03, 8'h01, 7'h28);
        t(mie_pkg::MIE_OP_ROR_MEM, 8'h5, 8'h0, 8'h01, 8'h0, 7'h2a, 8'h0, 8'h80, 7'h2a);
        t(mie_pkg::MIE_OP_BRANCH, 8'h02, 8'hab, 8'h66, 8'h66, 7'h55, 8'h66, 8'h66, 7'h55);
        rd(12'h00c);
        chk("pc", 32'h2ab, q);
        t(mie_pkg::MIE_OP_IDLE, 8'h5, 8'h0, 8'h66, 8'h66, 7'h2a, 8'h66, 8'h66, 7'h2a);
        rd(12'h00c);
        chk("pc", 32'h2ac, q);
        // Power-down keeps memory and bumps the counter
        wr(12'h008, 32'h20);
        wr(12'h000, {11'h0, mie_pkg::MIE_OP_SLEEP, 8'h0, 8'h0});
        poll(32'h2);
        chk("clock run", 32'h0, {31'h0, sys_clk_run});
        chk("wdog clear seen", 32'h1, {31'h0, wd_seen});
        rd(12'h008);
        chk("flags", 32'h10, q);
        rd(12'h00c);
        chk("pc", 32'h2ad, q);
        wake_req <= 1'b1;
        poll(32'h0);
        wake_req <= 1'b0;
        rd(ma(8'h5));
        chk("mem kept", 32'h66, q);
        wr(12'h010, 32'h155);
        rd(12'h010);
        chk("stack", 32'h155, q);
        t(mie_pkg::MIE_OP_RET_IRQ, 8'h5, 8'h0, 8'h01, 8'h0, 7'h00, 8'h0, 8'h01, 7'h40);
        rd(12'h00c);
        chk("pc", 32'h155, q);
        t(mie_pkg::MIE_OP_RET, 8'h5, 8'h0, 8'h01, 8'h0, 7'h2a, 8'h0, 8'h01, 7'h2a);
        rd(12'h00c);
        chk("pc", 32'h155, q);
        t(mie_pkg::MIE_OP_RET_VAL, 8'h5, 8'h44, 8'h01, 8'h0, 7'h55, 8'h44, 8'h01, 7'h55);
        // Second command while a return is still busy must bounce
        apb(1'b1, 12'h000, {11'h0, mie_pkg::MIE_OP_RET_VAL, 8'h0, 8'h21});
        apb(1'b1, 12'h000, {11'h0, mie_pkg::MIE_OP_MOV_IMM, 8'h0, 8'h99});
        chk("busy refusal", 32'h1, {31'h0, e});
        rel();
        poll(32'h0);
        rd(12'h004);
        chk("acc", 32'h21, q);
        summarize();
    end
endmodule
